// >>> design/tmp_pkg.sv
// package: constants and carriers for the three-port pin logic
// Operation
// - four-bit port; bit 2 is output only, never read, drives a high-current indicator.
// - four-bit port bits 3, 1, 0 are bidirectional with separate pull-up selects.
// - eight-bit input-only port; one common pull-up select covers all eight pins.
// - enabling an input pin's special function switches that pin's pull-up off.
// - eight-bit bidirectional port, each pin with its own pull-up select.
// - the external reset releases every pin to high impedance even without a clock; rst_n does so only at an mclk edge.
// - a low external reset longer than 50 ns resets the pins, clock or not.
package tmp_pkg;
  localparam int unsigned A_WIDTH = 4;
  localparam int unsigned B_WIDTH = 8;
  localparam int unsigned D_WIDTH = 8;
  localparam int unsigned LED_BIT = 2;

  // bits of the four-bit port that are really bidirectional
  localparam logic [A_WIDTH-1:0] A_BIDIR_MASK = 4'hb;

  localparam int unsigned MCLK_PERIOD_NS = 4;
  localparam int unsigned EXT_RST_MIN_NS = 50;
  localparam int unsigned EXT_RST_MIN_CYC =
    (EXT_RST_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  typedef struct packed {
    logic [A_WIDTH-1:0] a_out;
    logic [A_WIDTH-1:0] a_dir;
    logic [A_WIDTH-1:0] a_pull_sel;
    logic               b_pull_all;
    logic [B_WIDTH-1:0] b_special_en;
    logic [D_WIDTH-1:0] d_out;
    logic [D_WIDTH-1:0] d_dir;
    logic [D_WIDTH-1:0] d_pull_sel;
  } tmp_cfg_s;

  typedef struct packed {
    logic [A_WIDTH-1:0] a_o;
    logic [A_WIDTH-1:0] a_oe_n;
    logic [A_WIDTH-1:0] a_pu;
    logic [B_WIDTH-1:0] b_pu;
    logic [D_WIDTH-1:0] d_o;
    logic [D_WIDTH-1:0] d_oe_n;
    logic [D_WIDTH-1:0] d_pu;
  } tmp_pad_s;

  typedef struct packed {
    logic [A_WIDTH-1:0] a_in;
    logic [B_WIDTH-1:0] b_in;
    logic [D_WIDTH-1:0] d_in;
  } tmp_rd_s;

  // every pin released: no drive, no pull-up
  localparam tmp_pad_s PAD_RESET = '{
    a_o: 4'h0, a_oe_n: 4'hf, a_pu: 4'h0, b_pu: 8'h00,
    d_o: 8'h00, d_oe_n: 8'hff, d_pu: 8'h00};
  localparam tmp_rd_s RD_RESET = '{a_in: 4'h0, b_in: 8'h00, d_in: 8'h00};
endpackage

// >>> design/tmp_ports.sv
// pin-level logic for the four-bit, input-only and eight-bit ports
module tmp_ports (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        ext_rst_n,
  input  wire tmp_pkg::tmp_cfg_s           cfg,
  input  wire logic [tmp_pkg::A_WIDTH-1:0] four_bit_port_pins_i,
  input  wire logic [tmp_pkg::B_WIDTH-1:0] input_port_pins_i,
  input  wire logic [tmp_pkg::D_WIDTH-1:0] eight_bit_io_pins_i,
  output tmp_pkg::tmp_pad_s                pad,
  output tmp_pkg::tmp_rd_s                 rd,
  output logic                             led_drive_pin
);
  logic [tmp_pkg::A_WIDTH-1:0] a_sync;
  logic [tmp_pkg::B_WIDTH-1:0] b_sync;
  logic [tmp_pkg::D_WIDTH-1:0] d_sync;
  logic [tmp_pkg::A_WIDTH-1:0] a_is_out;
  logic [tmp_pkg::A_WIDTH-1:0] a_oe_n;
  logic [tmp_pkg::A_WIDTH-1:0] a_pu;
  logic [tmp_pkg::A_WIDTH-1:0] a_in_mask;
  logic [tmp_pkg::B_WIDTH-1:0] b_pu_sel;
  logic [tmp_pkg::D_WIDTH-1:0] d_oe_n;
  logic [tmp_pkg::D_WIDTH-1:0] d_pu;
  logic                        led_level;
  logic                        pads_released;
  tmp_pkg::tmp_pad_s           next_pad;
  tmp_pkg::tmp_rd_s            next_rd;
  logic                        ext_rst_n_sync;
  logic                        ext_rst_meta;

  // output enables are active low on every two-way pin
  function automatic logic drive_to_oe_n(input logic is_out);
    return !is_out;
  endfunction

  // a pull-up would fight a driver or a special function, so it
  // is only granted while nothing else owns the pin
  function automatic logic pull_granted(input logic sel,
                                        input logic owned);
    return sel && !owned;
  endfunction

  // the led bit must exist and must not be marked two-way
  if (tmp_pkg::LED_BIT >= tmp_pkg::A_WIDTH) begin : g_bad_led
    $error("tmp_ports: led bit lies outside the four-bit port");
  end
  if (tmp_pkg::A_BIDIR_MASK[tmp_pkg::LED_BIT] !== 1'b0) begin : g_bad_mask
    $error("tmp_ports: led bit is marked bidirectional");
  end

  // the led bit always drives out and has no input path
  for (genvar i = 0; i < tmp_pkg::A_WIDTH; i++) begin : g_port_a
    if (tmp_pkg::A_BIDIR_MASK[i]) begin : g_bidir
      assign a_is_out[i]  = cfg.a_dir[i];
      assign a_in_mask[i] = 1'b1;
    end else begin : g_led
      assign a_is_out[i]  = 1'b1;
      assign a_in_mask[i] = 1'b0;
    end
    assign a_oe_n[i] = drive_to_oe_n(a_is_out[i]);
    assign a_pu[i]   = pull_granted(cfg.a_pull_sel[i], a_is_out[i]);
  end

  // one common select, but a live special function wins per pin
  for (genvar i = 0; i < tmp_pkg::B_WIDTH; i++) begin : g_port_b
    assign b_pu_sel[i] = pull_granted(cfg.b_pull_all, cfg.b_special_en[i]);
  end

  for (genvar i = 0; i < tmp_pkg::D_WIDTH; i++) begin : g_port_d
    assign d_oe_n[i] = drive_to_oe_n(cfg.d_dir[i]);
    assign d_pu[i]   = pull_granted(cfg.d_pull_sel[i], cfg.d_dir[i]);
  end

  assign led_level     = cfg.a_out[tmp_pkg::LED_BIT];
  assign pads_released = rst_n && ext_rst_n_sync;

  assign next_pad.a_o    = cfg.a_out;
  assign next_pad.a_oe_n = a_oe_n;
  assign next_pad.a_pu   = a_pu;
  assign next_pad.b_pu   = b_pu_sel;
  assign next_pad.d_o    = cfg.d_out;
  assign next_pad.d_oe_n = d_oe_n;
  assign next_pad.d_pu   = d_pu;

  // the led pin never reads back as an input
  assign next_rd.a_in = a_sync & a_in_mask;
  assign next_rd.b_in = b_sync;
  assign next_rd.d_in = d_sync;

  tmp_sync #(.WIDTH(tmp_pkg::A_WIDTH)) u_sync_a (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (four_bit_port_pins_i),
    .sync_out (a_sync)
  );

  tmp_sync #(.WIDTH(tmp_pkg::B_WIDTH)) u_sync_b (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (input_port_pins_i),
    .sync_out (b_sync)
  );

  tmp_sync #(.WIDTH(tmp_pkg::D_WIDTH)) u_sync_d (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (eight_bit_io_pins_i),
    .sync_out (d_sync)
  );

  // released copy of the external reset, used only to hold pins off
  // until the core reset path has caught up after release
  always_ff @(posedge mclk or negedge ext_rst_n) begin
    if (!ext_rst_n) begin
      ext_rst_meta   <= 1'b0;
      ext_rst_n_sync <= 1'b0;
    end else begin
      ext_rst_meta   <= 1'b1;
      ext_rst_n_sync <= ext_rst_meta;
    end
  end

  // pad drive is cleared asynchronously by ext_rst_n (rst_n only at an mclk edge) so a stopped clock still floats pins
  always_ff @(posedge mclk or negedge ext_rst_n) begin
    if (!ext_rst_n) begin
      pad           <= tmp_pkg::PAD_RESET;
      led_drive_pin <= 1'b0;
    end else if (!pads_released) begin
      pad           <= tmp_pkg::PAD_RESET;
      led_drive_pin <= 1'b0;
    end else begin
      pad           <= next_pad;
      led_drive_pin <= led_level;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd <= tmp_pkg::RD_RESET;
    end else begin
      rd <= next_rd;
    end
  end
endmodule

// >>> design/tmp_sync.sv
// two-flop synchroniser for pin levels entering the mclk domain
module tmp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // a zero-width synchroniser has nothing to carry
  if (WIDTH < 1) begin : g_bad_width
    $error("tmp_sync: WIDTH must be at least 1");
  end

  // stage1 feeds sync_out only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// >>> verif/tiny_mcu_port_pins_tb_top.sv
// bench for tmp_ports
module tiny_mcu_port_pins_tb_top;
  timeunit 1ns / 1ps;
  logic mclk = 1'b0, rst_n = 1'b0, ext_rst_n = 1'b1, led_drive_pin;
  logic [7:0] en = 8'h0f, v = 8'h0a;
  int failures, check_count;
  tmp_pkg::tmp_cfg_s cfg = '0;
  tmp_pkg::tmp_pad_s pad;
  tmp_pkg::tmp_rd_s pin, rd;
  tmp_ports dut (.mclk, .rst_n, .ext_rst_n, .cfg, .four_bit_port_pins_i(pin.a_in),
    .input_port_pins_i(pin.b_in), .eight_bit_io_pins_i(pin.d_in), .pad, .rd, .led_drive_pin);
  tmp_pin_model far (.pad, .en, .v, .pin);
  initial forever #2 mclk = ~mclk;
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(input logic ok);
    check_count++;
    if (ok !== 1'b1) failures++;
    if (ok !== 1'b1) $display("MISMATCH %0t pin state", $time);
  endtask
  task close_out;
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task pulls;
    cfg = {4'h4, 4'h1, 4'hf, 1'h1, 8'h0f, 8'h05, 8'h0f, 8'hff};
    step(5);
    chk(led_drive_pin === 1'b1 && pad.a_pu === 4'ha && pad.b_pu === 8'hf0);
    chk(pad.d_pu === 8'hf0 && rd === {4'ha, 8'hfa, 8'hf5});
  endtask
  task drives;
    cfg = {4'hb, 4'hf, 4'hf, 1'h0, 8'h00, 8'ha5, 8'hff, 8'hff};
    step(5);
    chk(led_drive_pin === 1'b0 && pad.a_o === 4'hb && pad.a_oe_n === 4'h0 && pad.a_pu === 4'h0);
    chk(pad.b_pu === 8'h00 && pad.d_oe_n === 8'h00 && pad.d_pu === 8'h00);
    chk(rd === {4'hb, 8'hfa, 8'ha5});
  endtask
  task resets;
    ext_rst_n = 1'b0;
    #1 chk(pad === tmp_pkg::PAD_RESET && led_drive_pin === 1'b0);
    step(tmp_pkg::EXT_RST_MIN_CYC);
    ext_rst_n = 1'b1;
    step(2);
    chk(pad === tmp_pkg::PAD_RESET);
    step(1);
    chk(pad.a_oe_n === 4'h0 && pad.d_oe_n === 8'h00 && pad.d_o === 8'ha5);
    rst_n = 1'b0;
    step(1);
    chk(pad === tmp_pkg::PAD_RESET && rd === tmp_pkg::RD_RESET && led_drive_pin === 1'b0);
    rst_n = 1'b1;
    step(1);
    chk(pad.a_o === 4'hb && pad.d_oe_n === 8'h00);
  endtask
  initial begin
    step(8);
    rst_n = 1'b1;
    pulls();
    drives();
    resets();
    close_out();
  end
endmodule

// >>> verif/tmp_pin_model.sv
// far-side model: port b drivers, pull-ups, open pins
module tmp_pin_model (
  input wire tmp_pkg::tmp_pad_s pad,
  input wire logic [7:0]        en,
  input wire logic [7:0]        v,
  output tmp_pkg::tmp_rd_s      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // open unpulled pins show the inverse of their last level, so no steady guess passes
  assign pin.a_in = ~pad.a_oe_n & pad.a_o | pad.a_oe_n & (pad.a_pu | ~pad.a_o);
  assign pin.b_in = en & v | ~en & (pad.b_pu | ~v);
  assign pin.d_in = ~pad.d_oe_n & pad.d_o | pad.d_oe_n & (pad.d_pu | ~pad.d_o);
endmodule

// >>> verif/tmp_ports_assertions.sv
// checker for tmp_ports pad rules
module tmp_chk (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              ext_rst_n,
  input wire tmp_pkg::tmp_cfg_s cfg,
  input wire tmp_pkg::tmp_pad_s pad,
  input wire logic              led_drive_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  tmp_pkg::tmp_cfg_s q;
  always_ff @(posedge mclk) q <= cfg;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence run; (rst_n && ext_rst_n)[*4]; endsequence // spans the release sync
  sequence ext_release; !ext_rst_n ##1 ext_rst_n; endsequence
  sequence pins_off; pad == tmp_pkg::PAD_RESET && !led_drive_pin; endsequence
  led_on_a: assert property (run |-> led_drive_pin == q.a_out[2] && !pad.a_oe_n[2]) else $error("led");
  a_dir_a: assert property (run |-> pad.a_oe_n == ~(q.a_dir | 4'h4)) else $error("a dir");
  a_pull_a: assert property (run |-> pad.a_pu == (q.a_pull_sel & ~q.a_dir & 4'hb)) else $error("a pu");
  b_pull_a: assert property (run |-> pad.b_pu == ({8{q.b_pull_all}} & ~q.b_special_en)) else $error("b pu");
  d_pull_a: assert property (run |-> pad.d_pu == (q.d_pull_sel & ~q.d_dir)) else $error("d pu");
  d_out_a: assert property (run |-> pad.d_oe_n == ~q.d_dir && pad.d_o == q.d_out) else $error("d out");
  ext_hiz_a: assert property (!ext_rst_n |-> pad == tmp_pkg::PAD_RESET && !led_drive_pin) else $error("ext");
  rst_hiz_a: assert property ($rose(rst_n) |-> pad == tmp_pkg::PAD_RESET) else $error("rst");
  ext_hold_a: assert property (ext_release |-> pins_off[*3]) else $error("ext hold");
  a_out_a: assert property (run |-> pad.a_o == q.a_out) else $error("a out");
endmodule
bind tmp_ports tmp_chk chk (.mclk, .rst_n, .ext_rst_n, .cfg, .pad, .led_drive_pin);
